// ---- rtl/dbgp_break_access.sv ----
// debug port break qualification, forced reset, wake-up and the
// write-data / access-command path toward the cpu core.
// assumes the link side delivers whole bytes on link_clk, the core side
// runs on mclk, and the cpu reports fetches and retirements on mclk.
`timescale 1ns/100ps
`default_nettype none

module dbgp_break_access (
  // core clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // debug link side, on the link clock
  input wire logic link_clk,
  input wire logic link_byte_valid,
  input wire logic link_addr_phase,
  input wire logic [7:0] link_byte,
  // cpu status, on mclk
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_fetch,
  input wire logic cpu_instr_done,
  input wire logic [23:0] cpu_rd_data,
  input wire logic cpu_rd_valid,
  input wire logic chip_reset_done,
  // break and control toward the cpu
  output logic cpu_break,
  output logic force_chip_reset,
  output logic cpu_wake,
  // register or memory operation request
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [23:0] cmd_wdata,
  // read data registers for the link to return
  output logic [7:0] read_data_upper,
  output logic [7:0] read_data_high,
  output logic [7:0] read_data_low
);

  // link-domain state: address counter and the byte handed across
  typedef struct packed {
    logic [7:0] addr_cnt;
    logic [7:0] xfer_addr;
    logic [7:0] xfer_data;
    logic xfer_tgl;
  } dbgp_link_s;

  // core-domain state
  typedef struct packed {
    logic tgl_sync1;
    logic tgl_sync2;
    logic tgl_seen;
    logic [7:0] break_control;
    logic [7:0] slot0_compare_upper;
    logic [7:0] slot0_compare_high;
    logic [7:0] slot0_compare_low;
    logic [7:0] write_data_upper;
    logic [7:0] write_data_high;
    logic [7:0] write_data_low;
    logic force_reset;
    logic wake;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [23:0] cmd_wdata;
    logic [7:0] read_data_upper;
    logic [7:0] read_data_high;
    logic [7:0] read_data_low;
  } dbgp_core_s;

  dbgp_link_s link_reg;
  dbgp_link_s link_next;
  dbgp_core_s core_reg;
  dbgp_core_s core_next;

  logic byte_event;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic slot0_hit;

  // slot 0 compare; with page ignore only the page number is checked
  function automatic logic dbgp_slot_match(
    input logic [23:0] addr,
    input logic [23:0] cmp,
    input logic page_ignore
  );
    logic upper_eq;
    logic low_eq;
    upper_eq = addr[dbgp_pkg::CPU_ADDR_W-1:dbgp_pkg::PAGE_BITS] ==
               cmp[dbgp_pkg::CPU_ADDR_W-1:dbgp_pkg::PAGE_BITS];
    low_eq = addr[dbgp_pkg::PAGE_BITS-1:0] ==
             cmp[dbgp_pkg::PAGE_BITS-1:0];
    dbgp_slot_match = upper_eq && (page_ignore || low_eq);
  endfunction

  // link side: first byte of a transfer is the register address, every
  // following byte goes to the current address, which then steps by one
  always_comb begin
    link_next = link_reg;
    if (link_byte_valid) begin
      if (link_addr_phase) begin
        link_next.addr_cnt = link_byte;
      end else begin
        link_next.xfer_addr = link_reg.addr_cnt;
        link_next.xfer_data = link_byte;
        link_next.xfer_tgl = ~link_reg.xfer_tgl;
        link_next.addr_cnt = link_reg.addr_cnt + 8'h01;
      end
    end
  end

  // link registers; the clock may stop between frames, nothing here
  // needs an edge after the last byte because the toggle already moved
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // byte handover: the toggle is synchronised, the address and data words
  // are held still until the next byte, so they are sampled only after
  // the toggle has settled in this domain
  assign byte_event = core_reg.tgl_sync2 ^ core_reg.tgl_seen;
  assign wr_addr = link_reg.xfer_addr;
  assign wr_byte = link_reg.xfer_data;

  // slot 0 qualification on opcode fetches only
  assign slot0_hit = cpu_fetch &&
    core_reg.break_control[dbgp_pkg::MATCH_SLOT0_ENABLE_BIT] &&
    dbgp_slot_match(cpu_addr,
      {core_reg.slot0_compare_upper, core_reg.slot0_compare_high,
       core_reg.slot0_compare_low},
      core_reg.break_control[dbgp_pkg::PAGE_IGNORE_SLOT0_BIT]);

  // core next-state: register writes, break, reset and command launch
  always_comb begin
    core_next = core_reg;
    core_next.tgl_sync1 = link_reg.xfer_tgl;
    core_next.tgl_sync2 = core_reg.tgl_sync1;
    core_next.tgl_seen = core_reg.tgl_sync2;
    core_next.wake = 1'b0;
    core_next.cmd_valid = 1'b0;

    // the chip reset request drops once the reset controller reports done
    if (chip_reset_done) begin
      core_next.force_reset = 1'b0;
    end

    if (byte_event) begin
      unique case (wr_addr)
        dbgp_pkg::ADDR_SLOT0_LOW: begin
          core_next.slot0_compare_low = wr_byte;
        end
        dbgp_pkg::ADDR_SLOT0_HIGH: begin
          core_next.slot0_compare_high = wr_byte;
        end
        dbgp_pkg::ADDR_SLOT0_UPPER: begin
          core_next.slot0_compare_upper = wr_byte;
        end
        dbgp_pkg::ADDR_BREAK_CONTROL: begin
          // a zero in bit 7 releases the cpu from its break
          core_next.break_control = wr_byte;
        end
        dbgp_pkg::ADDR_MASTER_CONTROL: begin
          // write-only: nothing is kept but the reset request
          core_next.wake = 1'b1;
          if (wr_byte[dbgp_pkg::FORCE_CHIP_RESET_BIT]) begin
            core_next.force_reset = 1'b1;
          end
        end
        dbgp_pkg::ADDR_WRITE_DATA_UPPER: begin
          core_next.write_data_upper = wr_byte;
        end
        dbgp_pkg::ADDR_WRITE_DATA_HIGH: begin
          core_next.write_data_high = wr_byte;
        end
        dbgp_pkg::ADDR_WRITE_DATA_LOW: begin
          core_next.write_data_low = wr_byte;
        end
        dbgp_pkg::ADDR_ACCESS_COMMAND: begin
          // data comes from the bytes already held, not this one
          core_next.cmd_valid = 1'b1;
          core_next.cmd_code = wr_byte;
          core_next.cmd_wdata = {core_reg.write_data_upper,
                                 core_reg.write_data_high,
                                 core_reg.write_data_low};
        end
        default: begin
          // unmapped addresses are ignored
        end
      endcase
    end

    // hardware break sources win over a release in the same cycle
    if (slot0_hit) begin
      core_next.break_control[dbgp_pkg::BRK_NEXT_BIT] = 1'b1;
    end
    if (cpu_instr_done &&
        core_reg.break_control[dbgp_pkg::SINGLE_STEP_BIT]) begin
      core_next.break_control[dbgp_pkg::BRK_NEXT_BIT] = 1'b1;
    end

    // read results land in the read data bytes
    if (cpu_rd_valid) begin
      core_next.read_data_upper = cpu_rd_data[23:16];
      core_next.read_data_high = cpu_rd_data[15:8];
      core_next.read_data_low = cpu_rd_data[7:0];
    end
  end

  // core registers; write data bytes carry no meaningful reset value,
  // they are cleared only so that simulation starts from known levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_reg <= '0;
      core_reg.break_control <= dbgp_pkg::BREAK_CONTROL_RST;
      core_reg.write_data_upper <= dbgp_pkg::BYTE_RST;
      core_reg.write_data_high <= dbgp_pkg::BYTE_RST;
      core_reg.write_data_low <= dbgp_pkg::BYTE_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  // outputs straight from the core flops
  assign cpu_break = core_reg.break_control[dbgp_pkg::BRK_NEXT_BIT];
  assign force_chip_reset = core_reg.force_reset;
  assign cpu_wake = core_reg.wake;
  assign cmd_valid = core_reg.cmd_valid;
  assign cmd_code = core_reg.cmd_code;
  assign cmd_wdata = core_reg.cmd_wdata;
  assign read_data_upper = core_reg.read_data_upper;
  assign read_data_high = core_reg.read_data_high;
  assign read_data_low = core_reg.read_data_low;

endmodule

`default_nettype wire

// ---- rtl/dbgp_pkg.sv ----
// debug port break and access: shared constants
// assumes byte-wide debug registers reached over the serial debug link
package dbgp_pkg;

  // debug register addresses in the write space
  localparam logic [7:0] ADDR_SLOT0_LOW = 8'h00;
  localparam logic [7:0] ADDR_SLOT0_HIGH = 8'h01;
  localparam logic [7:0] ADDR_SLOT0_UPPER = 8'h02;
  localparam logic [7:0] ADDR_BREAK_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_MASTER_CONTROL = 8'h11;
  localparam logic [7:0] ADDR_WRITE_DATA_UPPER = 8'h13;
  localparam logic [7:0] ADDR_WRITE_DATA_HIGH = 8'h14;
  localparam logic [7:0] ADDR_WRITE_DATA_LOW = 8'h15;
  localparam logic [7:0] ADDR_ACCESS_COMMAND = 8'h16;

  // break_control field positions
  localparam int BRK_NEXT_BIT = 7;
  localparam int MATCH_SLOT0_ENABLE_BIT = 3;
  localparam int PAGE_IGNORE_SLOT0_BIT = 1;
  localparam int SINGLE_STEP_BIT = 0;

  // master_control field positions
  localparam int FORCE_CHIP_RESET_BIT = 7;

  // reset values
  localparam logic [7:0] BREAK_CONTROL_RST = 8'h00;
  localparam logic [7:0] MASTER_CONTROL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // widths
  localparam int CPU_ADDR_W = 24;
  localparam int PAGE_BITS = 8;

endpackage

// ---- verification/dbgp_checker.sv ----
// assertions for the debug port break and access block, all on mclk
// assumes it is bound to dbgp_break_access and sees its ports only
`timescale 1ns/100ps
`default_nettype none
module dbgp_checker (
  // clock, reset and link strobe
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_byte_valid,
  // cpu side
  input wire logic [23:0] cpu_rd_data,
  input wire logic cpu_rd_valid,
  input wire logic chip_reset_done,
  // outputs watched
  input wire logic cpu_break,
  input wire logic force_chip_reset,
  input wire logic cpu_wake,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [23:0] cmd_wdata,
  input wire logic [7:0] read_data_upper,
  input wire logic [7:0] read_data_high,
  input wire logic [7:0] read_data_low
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [3:0] quiet_reg;
  // mclk cycles since link traffic; a link write needs a few to land
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) quiet_reg <= 4'hf;
    else if (link_byte_valid) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
  end
  sequence s_rd_taken;
    cpu_rd_valid;
  endsequence
  sequence s_reset_wait;
    force_chip_reset && !chip_reset_done;
  endsequence
  a_rd_capture: assert property (s_rd_taken |=>
    {read_data_upper, read_data_high, read_data_low} == $past(cpu_rd_data))
    else $error("read data not captured");
  a_rd_hold: assert property (!cpu_rd_valid |=>
    $stable({read_data_upper, read_data_high, read_data_low}))
    else $error("read data changed without a read");
  a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  a_cmd_source: assert property (
    ($changed(cmd_code) || $changed(cmd_wdata)) |-> cmd_valid)
    else $error("command fields moved without a command");
  a_wake_single: assert property (cpu_wake |=> !cpu_wake)
    else $error("wake pulse longer than one cycle");
  a_reset_hold: assert property (s_reset_wait |=> force_chip_reset)
    else $error("forced reset dropped before done");
  a_reset_drop: assert property (
    $fell(force_chip_reset) |-> $past(chip_reset_done))
    else $error("forced reset fell without done");
  a_break_release: assert property (
    $fell(cpu_break) |-> quiet_reg < 4'hc)
    else $error("break released without a link write");
endmodule
`default_nettype wire

// ---- verification/dbgp_link_master.sv ----
// debug master model: sends single bytes over the serial debug link
// assumes the block samples link_byte on the rising edge of link_clk
`timescale 1ns/100ps
`default_nettype none
module dbgp_link_master (
  // link toward the block
  output logic link_clk,
  output logic link_byte_valid,
  output logic link_addr_phase,
  output logic [7:0] link_byte
);
  // link clock rests low between frames
  initial begin
    link_clk = 1'b0;
    link_byte_valid = 1'b0;
    link_addr_phase = 1'b0;
    link_byte = 8'h00;
  end
  // one link cycle of 12 ns
  task automatic tick;
    #6 link_clk = 1'b1;
    #6 link_clk = 1'b0;
  endtask
  // gap idle ticks first; a gap of 4 keeps data bytes five link cycles apart
  task automatic put(input logic ph, input logic [7:0] b, input int gap);
    repeat (gap) tick();
    link_addr_phase = ph;
    link_byte = b;
    link_byte_valid = 1'b1;
    tick();
    link_byte_valid = 1'b0;
    link_byte = ~b; // released line must not show the old byte
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// bench for the debug port break and access block
// assumes the link master model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk, rst_n, link_clk, link_byte_valid, link_addr_phase, seen;
  logic cpu_fetch, cpu_instr_done, cpu_rd_valid, chip_reset_done;
  logic cpu_break, force_chip_reset, cpu_wake, cmd_valid;
  logic [7:0] link_byte, cmd_code, rd_u, rd_h, rd_l;
  logic [23:0] cpu_addr, cpu_rd_data, cmd_wdata;
  int bad_count = 0;
  int comparisons = 0;
  dbgp_link_master m (.link_clk(link_clk), .link_byte(link_byte),
    .link_byte_valid(link_byte_valid), .link_addr_phase(link_addr_phase));
  dbgp_break_access dut (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
    .link_byte_valid(link_byte_valid), .link_addr_phase(link_addr_phase),
    .link_byte(link_byte), .cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch),
    .cpu_instr_done(cpu_instr_done), .cpu_rd_data(cpu_rd_data),
    .cpu_rd_valid(cpu_rd_valid), .chip_reset_done(chip_reset_done),
    .cpu_break(cpu_break), .force_chip_reset(force_chip_reset),
    .cpu_wake(cpu_wake), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .read_data_upper(rd_u), .read_data_high(rd_h),
    .read_data_low(rd_l));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // wake is a one-cycle pulse, so latch it for later checking
  always @(posedge mclk) if (cpu_wake === 1'b1) seen <= 1'b1;
  task automatic chk(input string what, input logic [23:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // register write; the link side needs a few mclk to land
  task automatic wr(input logic [7:0] a, d);
    m.put(1'b1, a, 4);
    m.put(1'b0, d, 0);
    cyc(8);
  endtask
  task automatic fetch(input logic [23:0] a, input logic e);
    cpu_addr = a;
    pulse(cpu_fetch);
    chk("cpu_break", 24'(e), 24'(cpu_break));
  endtask
  task automatic wait_cmd(input logic [7:0] c, input logic [23:0] w);
    int n = 0;
    while (cmd_valid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("cmd_valid", 24'h1, 24'(cmd_valid));
    chk("cmd_code", 24'(c), 24'(cmd_code));
    chk("cmd_wdata", w, cmd_wdata);
    cyc(1);
    chk("cmd_valid end", 24'h0, 24'(cmd_valid));
  endtask
  task automatic t_cmd;
    m.put(1'b1, 8'h13, 4);
    m.put(1'b0, 8'ha5, 0);
    m.put(1'b0, 8'h5a, 4);
    m.put(1'b0, 8'h3c, 4);
    m.put(1'b0, 8'h81, 4);
    wait_cmd(8'h81, 24'ha55a3c);
    m.put(1'b1, 8'h16, 4);
    m.put(1'b0, 8'h01, 0);
    wait_cmd(8'h01, 24'ha55a3c);
    $display("test cmd done");
  endtask
  task automatic t_read;
    cpu_rd_data = 24'h123456;
    pulse(cpu_rd_valid);
    cpu_rd_data = 24'h987654;
    cyc(2);
    chk("read data", 24'h123456, {rd_u, rd_h, rd_l});
    $display("test read done");
  endtask
  task automatic t_match;
    m.put(1'b1, 8'h00, 4); // compare bytes low, high, upper
    m.put(1'b0, 8'h12, 0);
    m.put(1'b0, 8'hcd, 4);
    m.put(1'b0, 8'hab, 4);
    wr(8'h10, 8'h08);
    fetch(24'habcd13, 1'b0);
    fetch(24'habcd12, 1'b1);
    wr(8'h10, 8'h08);
    chk("break release", 24'h0, 24'(cpu_break));
    wr(8'h10, 8'h0a);
    fetch(24'habce12, 1'b0);
    fetch(24'habcdff, 1'b1);
    wr(8'h10, 8'h02);
    fetch(24'habcd12, 1'b0);
    wr(8'h10, 8'h01);
    pulse(cpu_instr_done);
    chk("step break", 24'h1, 24'(cpu_break));
    wr(8'h10, 8'h00);
    pulse(cpu_instr_done);
    chk("step off", 24'h0, 24'(cpu_break));
    $display("test break done");
  endtask
  task automatic t_reset;
    seen = 1'b0;
    wr(8'h11, 8'h00);
    chk("reset on zero", 24'h0, 24'(force_chip_reset));
    chk("wake", 24'h1, 24'(seen));
    wr(8'h11, 8'h80);
    cyc(4);
    chk("reset held", 24'h1, 24'(force_chip_reset));
    pulse(chip_reset_done);
    chk("reset clear", 24'h0, 24'(force_chip_reset));
    $display("test reset done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {cpu_fetch, cpu_instr_done, cpu_rd_valid, chip_reset_done} = 4'h0;
    cpu_addr = 24'h000000;
    cpu_rd_data = 24'h000000;
    cyc(10);
    rst_n = 1'b1;
    cyc(2);
    t_cmd();
    t_read();
    t_match();
    t_reset();
    close_out();
  end
  // the run needs a few microseconds; this limit is far beyond
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule
bind dbgp_break_access dbgp_checker chk_i (.mclk(mclk), .rst_n(rst_n),
  .link_byte_valid(link_byte_valid), .cpu_rd_data(cpu_rd_data),
  .cpu_rd_valid(cpu_rd_valid), .chip_reset_done(chip_reset_done),
  .cpu_break(cpu_break), .force_chip_reset(force_chip_reset),
  .cpu_wake(cpu_wake), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_wdata(cmd_wdata), .read_data_upper(read_data_upper),
  .read_data_high(read_data_high), .read_data_low(read_data_low));
`default_nettype wire
